// ===== verilog/synth_divider_control.sv
// Purpose: divider and selection logic of the three-loop synthesizer
// Assumes: reference and oscillator edges arrive as one-cycle ticks
//          synchronous to clk_i; link driven by the controller end
// Notes:   every derived rate but the keying tone (a level) leaves as a one-cycle pulse
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module synth_divider_control
  import synth_pkg::*;
#(
  parameter int SETTLE_CYC = `SETTLE_CYCLES
)
(
  input  wire logic    clk_i,
  input  wire logic    sys_rst_i,
  synth_link_if.device link,
  input  wire logic    ref_a_tick_i,
  input  wire logic    ref_b_tick_i,
  input  wire logic    fine_osc_tick_i,
  input  wire logic    middle_mix_tick_i,
  input  wire logic    middle_osc_tick_i,
  input  wire logic    main_mix_tick_i,
  output logic         fine_ref_o,
  output logic         fine_cmp_o,
  output logic         fine_step_o,
  output logic         middle_ref_o,
  output logic         middle_cmp_o,
  output logic         middle_step_o,
  output logic         main_ref_o,
  output logic         main_cmp_o,
  output logic         offset_inj_o,
  output logic         offset_path_o,
  output logic         marker_o,
  output logic         fsk_tone_o,
  output logic         tx_inhibit_o
);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  logic [`SER_BITS-1:0] shift_ff;
  logic [11:0]          fine_n_ff;
  logic [11:0]          middle_n_ff;
  logic [11:0]          main_n_ff;
  logic                 path_ff;
  logic [SW-1:0]        settle_ff;
  logic [SW-1:0]        nxt_settle;
  logic                 inhibit_ff;
  logic [11:0]          new_n;
  loop_sel_t            sel;
  logic                 in_range;
  logic                 take;
  logic                 changed;
  logic                 mhz_tick;
  logic [11:0]          tone_div;

  // ---------------------------------------------------------------
  // serial intake
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
    if (sys_rst_i)
      shift_ff <= {`SER_BITS{1'b0}};
    else if (link.ser_shift)
      shift_ff <= {shift_ff[`SER_BITS-2:0], link.ser_data};

  assign new_n = shift_ff[11:0];
  assign sel   = loop_sel_t'(shift_ff[13:12]);

  always_comb
  begin
    in_range = 1'b0;
    case (sel)
      SEL_MAIN:
        in_range = new_n >= `MAIN_N_MIN && new_n <= `MAIN_N_MAX;
      SEL_MIDDLE:
        in_range = new_n >= `MIDDLE_N_MIN && new_n <= `MIDDLE_N_MAX;
      SEL_FINE:
        in_range = new_n >= `FINE_N_MIN && new_n <= `FINE_N_MAX;
      default:
        in_range = 1'b0;
    endcase
  end

  // nothing reaches a divider before the latch strobe
  assign take = link.ser_latch && in_range;

  always_comb
  begin
    changed = 1'b0;
    case (sel)
      SEL_MAIN:   changed = take && (new_n != main_n_ff);
      SEL_MIDDLE: changed = take && (new_n != middle_n_ff);
      SEL_FINE:   changed = take && (new_n != fine_n_ff);
      default:    changed = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // applied ratios
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
    if (sys_rst_i)
      main_n_ff <= `MAIN_N_RST;
    else if (take && sel == SEL_MAIN)
      main_n_ff <= new_n;
  always_ff @(posedge clk_i)
    if (sys_rst_i)
      middle_n_ff <= `MIDDLE_N_RST;
    else if (take && sel == SEL_MIDDLE)
      middle_n_ff <= new_n;
  always_ff @(posedge clk_i)
    if (sys_rst_i)
      fine_n_ff <= `FINE_N_RST;
    else if (take && sel == SEL_FINE)
      fine_n_ff <= new_n;

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      path_ff <= 1'b0;
    else
      path_ff <= link.offset_path;

  // ---------------------------------------------------------------
  // settling inhibit
  // ---------------------------------------------------------------
  // any new ratio or path swap restarts the full settle time
  always_comb
  begin
    nxt_settle = settle_ff;
    if (changed || (link.offset_path != path_ff))
      nxt_settle = SW'(SETTLE_CYC);
    else if (settle_ff != {SW{1'b0}})
      nxt_settle = settle_ff - SW'(1);
  end

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      settle_ff <= {SW{1'b0}};
    else
      settle_ff <= nxt_settle;

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      inhibit_ff <= 1'b0;
    else
      inhibit_ff <= (nxt_settle != {SW{1'b0}});

  assign tx_inhibit_o    = inhibit_ff;
  assign link.tx_inhibit = inhibit_ff;
  assign offset_path_o   = path_ff;

  // ---------------------------------------------------------------
  // fine loop
  // ---------------------------------------------------------------
  div_stage u_fine_ref
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (ref_b_tick_i),
    .ratio_i   (`FINE_REF_DIV),
    .pulse_o   (fine_ref_o),
    .level_o   ()
  );
  div_stage u_fine_cmp
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (fine_osc_tick_i),
    .ratio_i   (fine_n_ff),
    .pulse_o   (fine_cmp_o),
    .level_o   ()
  );
  div_stage u_fine_step
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (fine_osc_tick_i),
    .ratio_i   (`FINE_OUT_DIV),
    .pulse_o   (fine_step_o),
    .level_o   ()
  );

  // ---------------------------------------------------------------
  // middle loop
  // ---------------------------------------------------------------
  div_stage u_middle_ref
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (ref_a_tick_i),
    .ratio_i   (`MIDDLE_REF_DIV),
    .pulse_o   (middle_ref_o),
    .level_o   ()
  );
  div_stage u_middle_cmp
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (middle_mix_tick_i),
    .ratio_i   (middle_n_ff),
    .pulse_o   (middle_cmp_o),
    .level_o   ()
  );
  div_stage u_middle_step
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (middle_osc_tick_i),
    .ratio_i   (`MIDDLE_OUT_DIV),
    .pulse_o   (middle_step_o),
    .level_o   ()
  );

  // ---------------------------------------------------------------
  // main loop and offset injection
  // ---------------------------------------------------------------
  div_stage u_main_ref
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (ref_a_tick_i),
    .ratio_i   (`MAIN_REF_DIV),
    .pulse_o   (main_ref_o),
    .level_o   ()
  );
  div_stage u_main_cmp
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (main_mix_tick_i),
    .ratio_i   (main_n_ff),
    .pulse_o   (main_cmp_o),
    .level_o   ()
  );
  div_stage u_offset
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (ref_a_tick_i),
    .ratio_i   (`OFFSET_DIV),
    .pulse_o   (offset_inj_o),
    .level_o   ()
  );

  // ---------------------------------------------------------------
  // marker and keying tones
  // ---------------------------------------------------------------
  // held in reset while off so no marker energy leaks out
  div_stage u_marker
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (link.marker_on),
    .tick_i    (ref_a_tick_i),
    .ratio_i   (`MARKER_DIV),
    .pulse_o   (marker_o),
    .level_o   ()
  );
  div_stage u_mhz
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (1'b1),
    .tick_i    (ref_a_tick_i),
    .ratio_i   (`MHZ_DIV),
    .pulse_o   (mhz_tick),
    .level_o   ()
  );

  // keying moves only the tone; the loop ratios stay put during mark
  assign tone_div = link.fsk_mark ? `MARK_DIV : `SPACE_DIV;

  div_stage u_tone
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (link.fsk_mode),
    .tick_i    (mhz_tick),
    .ratio_i   (tone_div),
    .pulse_o   (),
    .level_o   (fsk_tone_o)
  );
endmodule

// ===== verilog/synth_map.svh
// Purpose: constants of the synthesizer divider block and its controller
// Assumes: one 25 MHz system clock; frequencies held in 10 Hz units
// Notes:   shared by package, device end and controller end
`ifndef SYNTH_MAP_SVH
`define SYNTH_MAP_SVH
// Contract
// - fine reference is 10.24 MHz over 1024
// - fine feedback ratio 2000 to 2199
// - fine output is fine oscillator over 1000
// - fine ratio travels serially from controller
// - middle reference is 20 MHz over 1000
// - middle feedback ratio 490 to 739
// - middle oscillator divided by fixed 10
// - middle ratio also travels serially
// - direct path 9.5 to 19.49999 MHz, else offset
// - offset injection is 20 MHz halved
// - main feedback ratio 9 to 30
// - main reference is 20 MHz over 40
// - marker is 20 MHz over 200
// - marker divider halted while marker off
// - 1 MHz rate derived from 20 MHz
// - tone: 218 space or 235 mark, then 2
// - SHIFT_KEYING_MODE shows space frequency, steady during mark
// - indicated frequency depends on operating mode
// - frequency set in 10 Hz steps
// - controller computes and loads all three ratios
// - inhibit transmit until settled after changes

// ---------------------------------------------------------------
// divide ratios
// ---------------------------------------------------------------
`define FINE_REF_DIV    12'h400
`define FINE_N_MIN      12'h7D0
`define FINE_N_MAX      12'h897
`define FINE_OUT_DIV    12'h3E8
`define MIDDLE_REF_DIV  12'h3E8
`define MIDDLE_N_MIN    12'h1EA
`define MIDDLE_N_MAX    12'h2E3
`define MIDDLE_OUT_DIV  12'h00A
`define OFFSET_DIV      12'h002
`define MAIN_N_MIN      12'h009
`define MAIN_N_MAX      12'h01E
`define MAIN_REF_DIV    12'h028
`define MARKER_DIV      12'h0C8
`define MHZ_DIV         12'h014
`define SPACE_DIV       12'h0DA
`define MARK_DIV        12'h0EB
`define FINE_N_RST      12'h834
`define MIDDLE_N_RST    12'h235
`define MAIN_N_RST      12'h012
// ---------------------------------------------------------------
// serial frame: 2 select bits then 12 ratio bits, msb first
// ---------------------------------------------------------------
`define SER_BITS        14
// ---------------------------------------------------------------
// frequency plan in 10 Hz units
// ---------------------------------------------------------------
`define BAND_LO         22'h0E7EF0
`define BAND_HI         22'h1DC12F
`define OFFSET_UNITS    22'h0F4240
`define BASE_UNITS      22'h07A120
`define N1_STEP         22'h00C350
`define N2_STEP         22'h0000C8
`define FSK_SPACE_UNITS 22'h0000E5
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ          25000000
`define SETTLE_US       10000
`define SETTLE_CYCLES   (`SETTLE_US * (`CLK_HZ / 1000000))
// ---------------------------------------------------------------
// controller register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_FREQ        4'h4
`define REG_STAT        4'h8
`define REG_RATIO       4'hC
`endif

// ===== verilog/synth_pkg.sv
// Purpose: types shared by both ends of the synthesizer link
// Assumes: constants come from synth_map.svh
// Notes:   select codes follow declaration order
`include "synth_map.svh"
package synth_pkg;
  typedef enum logic [1:0] {SEL_MAIN, SEL_MIDDLE, SEL_FINE, SEL_NONE}
    loop_sel_t;
  typedef enum logic [1:0] {MODE_CW, MODE_SSB, MODE_AM, MODE_FSK} mode_t;
  typedef enum logic [2:0] {C_IDLE, C_CALC1, C_CALC2, C_SEND, C_LATCH}
    ctl_state_t;
endpackage

// ===== verilog/synth_link_if.sv
// Purpose: link between controller and synthesizer divider block
// Assumes: both ends on the same clock
// Notes:   all signals driven from flip-flops, except fsk_mode, a decode of the controller's mode register
`timescale 1ns/1ps
interface synth_link_if;
  logic ser_data;
  logic ser_shift;
  logic ser_latch;
  logic offset_path;
  logic marker_on;
  logic fsk_mode;
  logic fsk_mark;
  logic tx_inhibit;
  modport device
  (
    input  ser_data, ser_shift, ser_latch, offset_path,
    input  marker_on, fsk_mode, fsk_mark,
    output tx_inhibit
  );
  modport controller
  (
    output ser_data, ser_shift, ser_latch, offset_path,
    output marker_on, fsk_mode, fsk_mark,
    input  tx_inhibit
  );
endinterface

// ===== verilog/div_stage.sv
// Purpose: counts input tick pulses and emits one pulse every ratio ticks
// Assumes: ratio_i at least 1; tick_i one cycle wide
// Notes:   level_o toggles per output pulse, giving a further halving
`timescale 1ns/1ps
module div_stage
  import synth_pkg::*;
#(
  parameter int W = 12
)
(
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              pulse_o,
  output logic              level_o
);
  logic [W-1:0] cnt_ff;
  logic         pulse_ff;
  logic         level_ff;
  logic         wrap;

  // a ratio change takes effect mid-count; a count at or past the new end wraps on the next tick
  assign wrap = (cnt_ff >= ratio_i - W'(1));

  always_ff @(posedge clk_i)
    if (sys_rst_i || !run_i)
      cnt_ff <= {W{1'b0}};
    else if (tick_i)
      cnt_ff <= wrap ? {W{1'b0}} : cnt_ff + W'(1);

  always_ff @(posedge clk_i)
    if (sys_rst_i || !run_i)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= tick_i && wrap;

  always_ff @(posedge clk_i)
    if (sys_rst_i || !run_i)
      level_ff <= 1'b0;
    else if (tick_i && wrap)
      level_ff <= !level_ff;

  assign pulse_o = pulse_ff;
  assign level_o = level_ff;
endmodule

// ===== verilog/synth_controller.sv
// Purpose: controller end: computes loop ratios and loads them serially
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes:   a start while busy is ignored
`timescale 1ns/1ps
module synth_controller
  import synth_pkg::*;
#(
  parameter logic [21:0] AM_CENTRE = 22'h000000
)
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  synth_link_if.controller link,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  ctl_state_t  state_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [21:0] freq_ff;
  mode_t       mode_ff;
  logic        marker_ff;
  logic        mark_ff;
  logic [21:0] r_ff;
  logic [11:0] n1_ff;
  logic [11:0] n2_ff;
  logic [11:0] n3_ff;
  logic [1:0]  word_ff;
  logic [3:0]  bit_ff;
  logic [`SER_BITS-1:0] frame_ff;
  logic        sdata_ff;
  logic        sshift_ff;
  logic        slatch_ff;
  logic        path_ff;
  logic [21:0] carrier;
  logic        direct;
  logic        acc;
  logic        wr_ok;
  logic        start;

  // ---------------------------------------------------------------
  // bus slave: one wait cycle, then the transfer edge
  // ---------------------------------------------------------------
  assign acc   = avs_read_i || avs_write_i;
  assign wr_ok = avs_write_i && !wait_ff;
  assign start = wr_ok && avs_address_i == `REG_CTRL &&
                 avs_writedata_i[0] && state_ff == C_IDLE;

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      wait_ff <= 1'b1;
    else
      wait_ff <= !(acc && wait_ff);

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      rdata_ff <= 32'h00000000;
    else if (avs_read_i && wait_ff)
      case (avs_address_i)
        `REG_CTRL:  rdata_ff <= {27'h0, mark_ff, mode_ff, marker_ff, 1'b0};
        `REG_FREQ:  rdata_ff <= {10'h000, freq_ff};
        `REG_STAT:  rdata_ff <= {29'h0, path_ff, link.tx_inhibit,
                                 state_ff != C_IDLE};
        `REG_RATIO: rdata_ff <= {3'h0, n1_ff[4:0], n2_ff, n3_ff};
        default:    rdata_ff <= 32'h00000000;
      endcase

  always_ff @(posedge clk_i)
    if (sys_rst_i)
    begin
      marker_ff <= 1'b0;
      mode_ff   <= MODE_CW;
      mark_ff   <= 1'b0;
    end
    else if (wr_ok && avs_address_i == `REG_CTRL)
    begin
      marker_ff <= avs_writedata_i[1];
      mode_ff   <= mode_t'(avs_writedata_i[3:2]);
      mark_ff   <= avs_writedata_i[4];
    end

  always_ff @(posedge clk_i)
    if (sys_rst_i)
      freq_ff <= 22'h000000;
    else if (wr_ok && avs_address_i == `REG_FREQ)
      freq_ff <= avs_writedata_i[21:0];

  // ---------------------------------------------------------------
  // frequency plan
  // ---------------------------------------------------------------
  always_comb
  begin
    carrier = freq_ff;
    case (mode_ff)
      MODE_FSK: carrier = freq_ff - `FSK_SPACE_UNITS;
      MODE_AM:  carrier = freq_ff - AM_CENTRE;
      default:  carrier = freq_ff;
    endcase
  end

  assign direct = carrier >= `BAND_LO && carrier <= `BAND_HI;

  // ---------------------------------------------------------------
  // ratio calculation and serial load
  // ---------------------------------------------------------------
  // repeated subtraction: slow but tiny, at most about 280 cycles
  always_ff @(posedge clk_i)
    if (sys_rst_i)
    begin
      state_ff  <= C_IDLE;
      r_ff      <= 22'h000000;
      n1_ff     <= `MAIN_N_RST;
      n2_ff     <= `MIDDLE_N_RST;
      n3_ff     <= `FINE_N_RST;
      word_ff   <= 2'h0;
      bit_ff    <= 4'h0;
      frame_ff  <= {`SER_BITS{1'b0}};
      sdata_ff  <= 1'b0;
      sshift_ff <= 1'b0;
      slatch_ff <= 1'b0;
      path_ff   <= 1'b0;
    end
    else
    begin
      sshift_ff <= 1'b0;
      slatch_ff <= 1'b0;
      case (state_ff)
        C_IDLE:
          if (start)
          begin
            path_ff  <= !direct;
            r_ff     <= direct ? carrier - `BASE_UNITS :
                        carrier < `BAND_LO ?
                        carrier + `OFFSET_UNITS - `BASE_UNITS :
                        carrier - `OFFSET_UNITS - `BASE_UNITS;
            n1_ff    <= 12'h000;
            n2_ff    <= `MIDDLE_N_MIN;
            state_ff <= C_CALC1;
          end
        C_CALC1:
          if (r_ff >= `N1_STEP)
          begin
            r_ff  <= r_ff - `N1_STEP;
            n1_ff <= n1_ff + 12'h001;
          end
          else
            state_ff <= C_CALC2;
        C_CALC2:
          if (r_ff >= `N2_STEP)
          begin
            r_ff  <= r_ff - `N2_STEP;
            n2_ff <= n2_ff + 12'h001;
          end
          else
          begin
            n3_ff    <= `FINE_N_MIN + r_ff[11:0];
            word_ff  <= 2'h0;
            bit_ff   <= 4'h0;
            frame_ff <= {SEL_MAIN, n1_ff};
            state_ff <= C_SEND;
          end
        C_SEND:
        begin
          sshift_ff <= 1'b1;
          sdata_ff  <= frame_ff[`SER_BITS-1];
          frame_ff  <= {frame_ff[`SER_BITS-2:0], 1'b0};
          bit_ff    <= bit_ff + 4'h1;
          if (bit_ff == 4'(`SER_BITS - 1))
            state_ff <= C_LATCH;
        end
        C_LATCH:
        begin
          slatch_ff <= 1'b1;
          bit_ff    <= 4'h0;
          word_ff   <= word_ff + 2'h1;
          frame_ff  <= (word_ff == 2'h0) ? {SEL_MIDDLE, n2_ff} :
                                           {SEL_FINE, n3_ff};
          state_ff  <= (word_ff == 2'h2) ? C_IDLE : C_SEND;
        end
        default:
          state_ff <= C_IDLE;
      endcase
    end

  assign link.ser_data    = sdata_ff;
  assign link.ser_shift   = sshift_ff;
  assign link.ser_latch   = slatch_ff;
  assign link.offset_path = path_ff;
  assign link.marker_on   = marker_ff;
  assign link.fsk_mode    = (mode_ff == MODE_FSK);
  assign link.fsk_mark    = mark_ff;
  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
endmodule

// ===== tb/synth_link_sva.sv
// Purpose: protocol checks on the controller to divider link
// Assumes: one clock, synchronous active-high reset
// Notes:   SETTLE_CYC must match the divider instance
`timescale 1ns/1ps
module synth_link_sva
#(
  parameter int SETTLE_CYC = 20
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ser_shift,
  input wire logic ser_latch,
  input wire logic offset_path,
  input wire logic tx_inhibit
);
  // ----------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------
  logic [4:0]  shift_cnt_ff;
  logic [31:0] high_cnt_ff;
  logic [31:0] quiet_cnt_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || ser_latch)
      shift_cnt_ff <= 5'h00;
    else if (ser_shift)
      shift_cnt_ff <= shift_cnt_ff + 5'h01;
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !tx_inhibit)
      high_cnt_ff <= 32'h0;
    else
      high_cnt_ff <= high_cnt_ff + 32'h1;
  end
  // restarts on every cause of settling, so inhibit length is bounded
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || ser_latch || offset_path != $past(offset_path))
      quiet_cnt_ff <= 32'h0;
    else
      quiet_cnt_ff <= quiet_cnt_ff + 32'h1;
  end
  // ----------------------------------------------------------
  // frame shape and settling
  // ----------------------------------------------------------
  sequence burst_s;
    ser_shift [*7];
  endsequence
  sequence frame_s;
    burst_s ##1 burst_s ##1 ser_latch;
  endsequence
  shift_latch_excl_a: assert property (!(ser_shift && ser_latch))
    else $error("shift and latch high together");
  frame_shape_a: assert property ($rose(ser_shift) |-> frame_s)
    else $error("frame is not 14 shifts then latch");
  latch_count_a: assert property (ser_latch |-> shift_cnt_ff == 5'h0E)
    else $error("latch without a whole frame");
  latch_pulse_a: assert property (ser_latch |=> !ser_latch)
    else $error("latch longer than one cycle");
  inhibit_hold_a: assert property (
    $fell(tx_inhibit) |-> high_cnt_ff >= SETTLE_CYC - 1)
    else $error("inhibit released before settling");
  inhibit_end_a: assert property (
    tx_inhibit |-> quiet_cnt_ff <= SETTLE_CYC + 8)
    else $error("inhibit held too long");
  inhibit_cause_a: assert property (
    $rose(tx_inhibit) |-> quiet_cnt_ff <= 3)
    else $error("inhibit without a change");
  offset_steady_a: assert property (ser_shift |-> $stable(offset_path))
    else $error("path select moved during a frame");
  reset_idle_a: assert property (
    $fell(sys_rst_i) |-> !ser_shift && !ser_latch && !tx_inhibit)
    else $error("link busy right after reset");
endmodule

// ===== tb/synth_divider_control_tb.sv
// Purpose: both ends joined; checks divider rates and ratio loading
// Assumes: all reference ticks run every clock while run is high
// Notes:   gaps between output pulses give the divide ratios
`timescale 1ns/1ps
module synth_divider_control_tb
  import synth_pkg::*;
;
  localparam int ST = 20;
  localparam int EX[11] = '{4360, 200, 2, 18, 40, 10, 565, 1000, 1000,
                            2100, 1024};
  logic        clk_i, sys_rst_i, run;
  logic        ref_a_tick_i, ref_b_tick_i, fine_osc_tick_i;
  logic        middle_mix_tick_i, middle_osc_tick_i, main_mix_tick_i;
  logic        fine_ref_o, fine_cmp_o, fine_step_o, middle_ref_o;
  logic        middle_cmp_o, middle_step_o, main_ref_o, main_cmp_o;
  logic        offset_inj_o, offset_path_o, marker_o, fsk_tone_o;
  logic        tx_inhibit_o, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rv;
  logic [10:0] o, op;
  logic [31:0] rq[$], mq[$];
  int          cyc, errors, compares;
  int          ls[11], gp[11];
  synth_link_if link();
  synth_divider_control #(.SETTLE_CYC(ST)) u_synth_divider_control (.*);
  synth_controller u_synth_controller (.*);
  synth_link_sva #(.SETTLE_CYC(ST)) u_synth_link_sva (.clk_i, .sys_rst_i,
    .ser_shift(link.ser_shift), .ser_latch(link.ser_latch),
    .offset_path(link.offset_path), .tx_inhibit(link.tx_inhibit));
  assign {ref_a_tick_i, ref_b_tick_i, fine_osc_tick_i} = {3{run}};
  assign {middle_mix_tick_i, middle_osc_tick_i, main_mix_tick_i} = {3{run}};
  assign o = {fine_ref_o, fine_cmp_o, fine_step_o, middle_ref_o,
              middle_cmp_o, middle_step_o, main_ref_o, main_cmp_o,
              offset_inj_o, marker_o, fsk_tone_o};
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------
  // monitors
  // ----------------------------------------------------------
  // tone is a level, so every edge counts; the rest are pulses
  always @(negedge clk_i)
  begin
    cyc++;
    for (int i = 0; i < 11; i++)
      if (i == 0 ? o[0] !== op[0] : o[i] && !op[i])
      begin
        gp[i] = cyc - ls[i];
        ls[i] = cyc;
      end
    op = o;
  end
  always @(posedge clk_i)
    if (avs_read_i && !avs_waitrequest_o && rq.size() > 0)
      chk("readdata", avs_readdata_o & mq.pop_front(), rq.pop_front());
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // entered just after a rising edge; held until waitrequest is low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o && n < 100);
    if (avs_waitrequest_o)
      errors++;
    rv = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rdx(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task load(input logic [31:0] f, input logic [31:0] s, input logic off);
    int k;
    // mode must be plain carrier before start, as start reads the old mode
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, f);
    bus(1'b1, 4'h0, 32'h1);
    k = 0;
    do
    begin
      bus(1'b0, 4'h8, 32'h0);
      k++;
    end
    while (rv[0] && k < 2000);
    if (rv[0])
      errors++;
    bus(1'b0, 4'hC, 32'h0);
    chk("freq sum", 50000 * rv[28:24] + 200 * rv[23:12] + 400000
        + rv[11:0], s);
    wt(7000);
    chk("main ratio", gp[3], rv[28:24]);
    chk("middle ratio", gp[6], rv[23:12]);
    chk("fine ratio", gp[9], rv[11:0]);
    rdx(4'h8, {29'h0, off, 2'h0}, 32'h4);
    chk("offset path", offset_path_o, off);
  endtask
  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial
  begin
    int          p;
    logic [31:0] f;
    {run, avs_read_i, avs_write_i} = 3'h0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    op = 11'h000;
    sys_rst_i = 1'b1;
    wt(3);
    sys_rst_i <= 1'b0;
    void'($urandom(44));
    rdx(4'h8, 32'h0, 32'h7);
    rdx(4'h2, 32'h0, 32'hFFFFFFFF);
    run <= 1'b1;
    wt(4400);
    for (int i = 2; i < 11; i++)
      chk("divider gap", gp[i], EX[i]);
    p = ls[1];
    wt(500);
    chk("marker idle", ls[1], p);
    bus(1'b1, 4'h0, 32'h2);
    wt(500);
    chk("marker gap", gp[1], EX[1]);
    bus(1'b1, 4'h0, 32'hE);
    wt(9000);
    chk("space tone", gp[0], EX[0]);
    bus(1'b1, 4'h0, 32'h1E);
    wt(9500);
    chk("mark tone", gp[0], 4700);
    f = 950000 + $urandom_range(999999, 0);
    load(f, f, 1'b0);
    f = 15000 + $urandom_range(934999, 0);
    load(f, f + 1000000, 1'b1);
    stop_test;
  end
  initial
  begin
    wt(60000);
    errors++;
    stop_test;
  end
endmodule
